// >>> core/e1fc_pkg.sv
// Package: register map, field positions, reset values and timing constants of the framer control
package e1fc_pkg;
  // ==========================================================================
  // Register addresses (address nibble of the command byte)
  localparam logic [3:0] ADDR_RCV = 4'h1;
  localparam logic [3:0] ADDR_CMN = 4'h2;
  localparam logic [7:0] CMN_RESET = 8'h00;
  localparam logic [7:0] RCV_RESET = 8'h00;
  localparam logic [7:0] CMN_MASK = 8'h7f;
  localparam logic [7:0] RCV_MASK = 8'h3f;
  // ==========================================================================
  // Common control fields
  localparam int CMN_LOCAL_LOOPBACK = 0;
  localparam int CMN_SYNC_ALGORITHM_SELECT = 1;
  localparam int CMN_RX_CRC4_ENABLE = 2;
  localparam int CMN_TX_CRC4_ENABLE = 3;
  localparam int CMN_RX_HDB3_ENABLE = 4;
  localparam int CMN_TX_HDB3_ENABLE = 5;
  localparam int CMN_TX_ALIGN_FRAME_POSITION = 6;
  // Receive control fields
  localparam int RCV_RESYNC = 0;
  localparam int RCV_AUTO_RESYNC_DISABLE = 1;
  // ==========================================================================
  // Frame structure
  localparam logic [4:0] TS_ALIGN = 5'd0;
  localparam logic [4:0] TS_SIGNALING = 5'd16;
  localparam logic [5:0] CRC_MFAS_PATTERN = 6'b001011;
  // Resync thresholds
  localparam logic [1:0] FAS_ERR_LIMIT = 2'd3;
  localparam logic [1:0] CAS_ERR_LIMIT = 2'd2;
  localparam logic [9:0] CRC_WINDOW = 10'd1000;
  localparam logic [9:0] CRC_BAD_LIMIT = 10'd915;
  localparam logic [1:0] CRC_MF_NEEDED = 2'd2;
  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 200_000_000;
  localparam int CRC_MF_WAIT_MS = 12;
  localparam int CRC_MF_WAIT_NEW_MS = 8;
  localparam int CRC_MF_WAIT_CYC = CRC_MF_WAIT_MS * (CLK_HZ / 1000);
  localparam int CRC_MF_WAIT_NEW_CYC = CRC_MF_WAIT_NEW_MS * (CLK_HZ / 1000);
endpackage

// >>> core/e1fc_sp_if.sv
// Interface between the serial command port and the register bank
interface e1fc_sp_if;
  logic wr_stb;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic sdo;
  logic sdo_oe_n;
  modport port (output wr_stb, output addr, output wdata, input rdata,
                output sdo, output sdo_oe_n);
  modport regs (input wr_stb, input addr, input wdata, output rdata,
                input sdo, input sdo_oe_n);
endinterface

// >>> core/e1fc_serial_port.sv
// Serial command port: address/command byte then one data byte, LSB first
module e1fc_serial_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk_rise,
  input wire logic sclk_fall,
  input wire logic cs_n,
  input wire logic sdi,
  e1fc_sp_if.port sp
);
  import e1fc_pkg::*;

  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] acb_q;
  logic [7:0] rd_q;
  logic done_q;

  // ==========================================================================
  // Shift in on rising serial clock; a deasserted select restarts the frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      acb_q <= 8'h00;
      done_q <= 1'b0;
    end else if (cs_n) begin
      cnt_q <= 4'h0;
      done_q <= 1'b0;
    end else if (sclk_rise && !done_q) begin
      sh_q <= {sdi, sh_q[7:1]};
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == 4'h7) begin
        acb_q <= {sdi, sh_q[7:1]};
      end
      if (cnt_q == 4'hf) begin
        done_q <= 1'b1; // Extra bits after one byte are ignored
      end
    end
  end

  // Write strobe after the eighth data bit of a write command
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp.wr_stb <= 1'b0;
      sp.wdata <= 8'h00;
      sp.addr <= 4'h0;
    end else begin
      sp.wr_stb <= !cs_n && sclk_rise && !done_q && cnt_q == 4'hf && !acb_q[0];
      sp.wdata <= {sdi, sh_q[7:1]};
      sp.addr <= acb_q[4:1];
    end
  end

  // Read data leaves on falling edges; the pin is released except during a read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 8'h00;
      sp.sdo <= 1'b0;
      sp.sdo_oe_n <= 1'b1;
    end else if (cs_n) begin
      sp.sdo_oe_n <= 1'b1;
    end else if (sclk_fall && cnt_q >= 4'h8 && !done_q && acb_q[0]) begin
      if (cnt_q == 4'h8) begin
        sp.sdo <= sp.rdata[0];
        rd_q <= {1'b0, sp.rdata[7:1]};
      end else begin
        sp.sdo <= rd_q[0];
        rd_q <= {1'b0, rd_q[7:1]};
      end
      sp.sdo_oe_n <= 1'b0;
    end else if (sclk_fall && done_q) begin
      sp.sdo_oe_n <= 1'b1;
    end
  end
endmodule // e1fc_serial_port

// >>> core/e1fc_top.sv
// Framer control register bank with line coding, CRC4 insertion and resync control
// Functional notes
// - CCS mode: timeslot 16 from serial input
// - CCS framing ignores align-frame-position bit
// - CRC4 replaces international bit frames 0-12,14
// - Receive rails decoded AMI or HDB3
// - Common register written on receive clock
// - Loopback feeds transmit rails into receiver
// - Three bad alignment words restart search
// - Two bad CAS alignment words restart search
// - 915 of 1000 CRC errors restart
// - CRC4 multiframe sync within timeout, else restart
module e1fc_top #(
  parameter int CRC_MF_WAIT = e1fc_pkg::CRC_MF_WAIT_CYC,
  parameter int CRC_MF_WAIT_NEW = e1fc_pkg::CRC_MF_WAIT_NEW_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  input wire logic transmit_line_clock,
  input wire logic rx_line_clock,
  input wire logic rx_positive_rail,
  input wire logic rx_negative_rail,
  input wire logic transmit_serial_input,
  input wire logic signaling_data_input,
  input wire logic test_pin,
  input wire logic tx_ccs_mode,
  input wire logic tx_sig_from_input,
  input wire logic frame_aligned,
  input wire logic fas_word_ok,
  input wire logic fas_word_bad,
  input wire logic cas_word_ok,
  input wire logic cas_word_bad,
  input wire logic crc_word_ok,
  input wire logic crc_word_bad,
  input wire logic crc_mfas_found,
  output logic tx_positive_rail,
  output logic tx_negative_rail,
  output logic rx_data,
  output logic rx_data_valid,
  output logic resync_pulse,
  output logic crc4_sync,
  output logic [7:0] common_control,
  output logic [7:0] receive_control
);
  import e1fc_pkg::*;

  e1fc_sp_if sp ();

  // ==========================================================================
  // Pin synchronisers: all ten pins pass two flops before use
  logic [9:0] s1_q;
  logic [9:0] s2_q;
  logic [2:0] clk_old_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 10'h000;
      s2_q <= 10'h000;
      clk_old_q <= 3'h0;
    end else begin
      s1_q <= {test_pin, signaling_data_input, transmit_serial_input, rx_negative_rail,
               rx_positive_rail, rx_line_clock, transmit_line_clock, sdi, ~cs_n, sclk};
      s2_q <= s1_q;
      clk_old_q <= {s2_q[4], s2_q[3], s2_q[0]};
    end
  end
  logic sclk_rise, sclk_fall, tx_edge, pin_rx_edge, test_s;
  assign sclk_rise = s2_q[0] && !clk_old_q[0];
  assign sclk_fall = !s2_q[0] && clk_old_q[0];
  assign tx_edge = s2_q[3] && !clk_old_q[1];
  assign pin_rx_edge = s2_q[4] && !clk_old_q[2];
  assign test_s = s2_q[9];

  e1fc_serial_port u_port (
    .clk(clk),
    .rst_n(rst_n),
    .sclk_rise(sclk_rise),
    .sclk_fall(sclk_fall),
    .cs_n(~s2_q[1]),
    .sdi(s2_q[2]),
    .sp(sp)
  );

  // ==========================================================================
  // Registers
  logic [7:0] cmn_q;
  logic [7:0] rcv_q;
  logic pend_q;
  logic [3:0] pend_addr_q;
  logic [7:0] pend_data_q;
  logic rx_edge;
  logic loop_en, hdb_tx, hdb_rx, crc_tx, new_alg;
  assign loop_en = cmn_q[CMN_LOCAL_LOOPBACK];
  assign hdb_tx = cmn_q[CMN_TX_HDB3_ENABLE];
  assign hdb_rx = cmn_q[CMN_RX_HDB3_ENABLE];
  assign crc_tx = cmn_q[CMN_TX_CRC4_ENABLE];
  assign new_alg = cmn_q[CMN_SYNC_ALGORITHM_SELECT] || test_s;
  // Receive edge comes from the transmit clock while looped back
  assign rx_edge = loop_en ? tx_edge : pin_rx_edge;

  // Writes wait for a receive clock edge; a stopped receive clock stalls them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmn_q <= CMN_RESET;
      rcv_q <= RCV_RESET;
      pend_q <= 1'b0;
      pend_addr_q <= 4'h0;
      pend_data_q <= 8'h00;
    end else begin
      if (sp.wr_stb) begin
        pend_q <= 1'b1;
        pend_addr_q <= sp.addr;
        pend_data_q <= sp.wdata;
      end else if (pend_q && rx_edge) begin
        pend_q <= 1'b0;
        if (pend_addr_q == ADDR_CMN) begin
          cmn_q <= pend_data_q & CMN_MASK;
        end
        if (pend_addr_q == ADDR_RCV) begin
          rcv_q <= pend_data_q & RCV_MASK;
        end
      end
    end
  end
  assign sp.rdata = (sp.addr == ADDR_CMN) ? cmn_q : (sp.addr == ADDR_RCV) ? rcv_q : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      common_control <= CMN_RESET;
      receive_control <= RCV_RESET;
      sdo <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else begin
      common_control <= cmn_q;
      receive_control <= rcv_q;
      sdo <= sp.sdo;
      sdo_oe_n <= sp.sdo_oe_n;
    end
  end

  // ==========================================================================
  // Transmit frame counters and bit selection
  logic [2:0] bit_q;
  logic [4:0] ts_q;
  logic [3:0] frm_q;
  logic [3:0] crc_q;
  logic [3:0] crc_lat_q;
  logic [3:0] cas_frm;
  logic tx_bit, ib_slot;
  // Align offset only moves the CAS multiframe, never CCS framing
  assign cas_frm = frm_q ^ {3'b000, cmn_q[CMN_TX_ALIGN_FRAME_POSITION] && !tx_ccs_mode};
  assign ib_slot = crc_tx && ts_q == TS_ALIGN && bit_q == 3'd0 && frm_q != 4'd13 && frm_q != 4'd15;
  always_comb begin
    tx_bit = s2_q[7];
    if (ts_q == TS_SIGNALING && !tx_ccs_mode) begin
      if (cas_frm == 4'd0 && bit_q < 3'd4) begin
        tx_bit = 1'b0;
      end else if (tx_sig_from_input && bit_q >= 3'd4) begin
        tx_bit = s2_q[8];
      end
    end
    // In CCS mode the signaling input is ignored
    if (ib_slot) begin
      tx_bit = frm_q[0] ? CRC_MFAS_PATTERN[3'd5 - frm_q[3:1]]
                        : crc_lat_q[2'd3 - frm_q[2:1]];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_q <= 3'd0;
      ts_q <= 5'd0;
      frm_q <= 4'd0;
      crc_q <= 4'h0;
      crc_lat_q <= 4'h0;
    end else if (tx_edge) begin
      bit_q <= bit_q + 3'd1;
      if (bit_q == 3'd7) begin
        ts_q <= ts_q + 5'd1;
        if (ts_q == 5'd31) begin
          frm_q <= frm_q + 4'd1;
        end
      end
      // CRC4 over each half multiframe, with check bit slots counted as zero
      if (bit_q == 3'd7 && ts_q == 5'd31 && frm_q[2:0] == 3'd7) begin
        crc_lat_q <= crc_next(crc_q, tx_bit);
        crc_q <= 4'h0;
      end else begin
        crc_q <= crc_next(crc_q, tx_bit && !(ib_slot && !frm_q[0]));
      end
    end
  end

  function automatic logic [3:0] crc_next(input logic [3:0] c, input logic d);
    logic fb;
    fb = d ^ c[3];
    crc_next = {c[2], c[1], c[0] ^ fb, fb};
  endfunction

  // ==========================================================================
  // Line encoder: three-bit lookahead finds four-zero runs for HDB3
  logic [3:0] enc_sh_q;
  logic [1:0] sub_q;
  logic last_pol_q;
  logic odd_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enc_sh_q <= 4'h0;
      sub_q <= 2'd0;
      last_pol_q <= 1'b0;
      odd_q <= 1'b0;
      tx_positive_rail <= 1'b0;
      tx_negative_rail <= 1'b0;
    end else if (tx_edge) begin
      enc_sh_q <= {enc_sh_q[2:0], tx_bit};
      tx_positive_rail <= 1'b0;
      tx_negative_rail <= 1'b0;
      if (sub_q != 2'd0) begin
        sub_q <= sub_q - 2'd1;
        if (sub_q == 2'd1) begin
          tx_positive_rail <= last_pol_q; // Violation repeats last polarity
          tx_negative_rail <= !last_pol_q;
          odd_q <= 1'b0;
        end
      end else if (hdb_tx && enc_sh_q == 4'h0) begin
        sub_q <= 2'd3;
        if (!odd_q) begin
          tx_positive_rail <= !last_pol_q; // Balancing pulse keeps DC even
          tx_negative_rail <= last_pol_q;
          last_pol_q <= !last_pol_q;
        end
      end else if (enc_sh_q[3]) begin
        tx_positive_rail <= !last_pol_q; // Alternate mark inversion
        tx_negative_rail <= last_pol_q;
        last_pol_q <= !last_pol_q;
        odd_q <= !odd_q;
      end
    end
  end

  // ==========================================================================
  // Line decoder: a violation erases itself and the three bits before it
  logic rp, rn;
  logic [3:0] dec_sh_q;
  logic rx_pol_q;
  assign rp = loop_en ? tx_positive_rail : s2_q[5];
  assign rn = loop_en ? tx_negative_rail : s2_q[6];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_sh_q <= 4'h0;
      rx_pol_q <= 1'b0;
      rx_data <= 1'b0;
      rx_data_valid <= 1'b0;
    end else begin
      rx_data_valid <= rx_edge;
      if (rx_edge) begin
        rx_data <= dec_sh_q[3];
        if (rp || rn) begin
          rx_pol_q <= rp;
        end
        if (hdb_rx && (rp || rn) && rp == rx_pol_q) begin
          dec_sh_q <= 4'h0;
        end else begin
          dec_sh_q <= {dec_sh_q[2:0], rp || rn};
        end
      end
    end
  end

  // ==========================================================================
  // Resync control
  logic auto_en;
  logic [1:0] fas_err_q;
  logic [1:0] cas_err_q;
  logic [9:0] crc_win_q;
  logic [9:0] crc_bad_q;
  logic [31:0] mf_tmr_q;
  logic [1:0] mf_cnt_q;
  logic hunting_q;
  logic aligned_old_q;
  logic manual_old_q;
  logic fas_trip, cas_trip, crc_trip, mf_timeout, manual_trip;
  assign auto_en = !rcv_q[RCV_AUTO_RESYNC_DISABLE];
  assign fas_trip = auto_en && fas_word_bad && fas_err_q == FAS_ERR_LIMIT - 2'd1;
  assign cas_trip = auto_en && cas_word_bad && cas_err_q == CAS_ERR_LIMIT - 2'd1;
  assign crc_trip = new_alg && crc_word_bad && crc_bad_q >= CRC_BAD_LIMIT - 10'd1
                    && crc_win_q != CRC_WINDOW;
  assign mf_timeout = hunting_q
                      && mf_tmr_q >= (new_alg ? CRC_MF_WAIT_NEW : CRC_MF_WAIT) - 1;
  assign manual_trip = rcv_q[RCV_RESYNC] && !manual_old_q;

  // Consecutive error counters; a good word or a restart clears them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fas_err_q <= 2'd0;
      cas_err_q <= 2'd0;
    end else if (resync_pulse) begin
      fas_err_q <= 2'd0;
      cas_err_q <= 2'd0;
    end else begin
      if (fas_word_bad) begin
        fas_err_q <= fas_trip ? 2'd0 : fas_err_q + 2'd1;
      end else if (fas_word_ok) begin
        fas_err_q <= 2'd0;
      end
      if (cas_word_bad) begin
        cas_err_q <= cas_trip ? 2'd0 : cas_err_q + 2'd1;
      end else if (cas_word_ok) begin
        cas_err_q <= 2'd0;
      end
    end
  end

  // CRC word error rate over windows of 1000 words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_win_q <= 10'd0;
      crc_bad_q <= 10'd0;
    end else if (resync_pulse || (crc_win_q == CRC_WINDOW - 10'd1 && (crc_word_ok
                 || crc_word_bad))) begin
      crc_win_q <= 10'd0;
      crc_bad_q <= 10'd0;
    end else if (crc_word_ok || crc_word_bad) begin
      crc_win_q <= crc_win_q + 10'd1;
      crc_bad_q <= crc_bad_q + {9'd0, crc_word_bad};
    end
  end

  // CRC4 multiframe hunt starts when frame alignment is gained
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hunting_q <= 1'b0;
      mf_tmr_q <= 32'd0;
      mf_cnt_q <= 2'd0;
      crc4_sync <= 1'b0;
      aligned_old_q <= 1'b0;
    end else begin
      aligned_old_q <= frame_aligned;
      if (resync_pulse || !frame_aligned) begin
        hunting_q <= 1'b0;
        crc4_sync <= 1'b0;
      end else if (frame_aligned && !aligned_old_q && cmn_q[CMN_RX_CRC4_ENABLE]) begin
        hunting_q <= 1'b1;
        mf_tmr_q <= 32'd0;
        mf_cnt_q <= 2'd0;
      end else if (hunting_q) begin
        mf_tmr_q <= mf_tmr_q + 32'd1;
        // Stop hunting as the restart leaves, so the timeout pulse lasts one cycle
        if (mf_timeout && !crc_mfas_found) begin
          hunting_q <= 1'b0;
        end
        if (crc_mfas_found) begin
          mf_cnt_q <= mf_cnt_q + 2'd1;
          if (mf_cnt_q == CRC_MF_NEEDED - 2'd1) begin
            crc4_sync <= 1'b1;
            hunting_q <= 1'b0;
          end
        end
      end
    end
  end

  // One restart pulse for any trip; software resync acts on a rising bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resync_pulse <= 1'b0;
      manual_old_q <= 1'b0;
    end else begin
      manual_old_q <= rcv_q[RCV_RESYNC];
      resync_pulse <= fas_trip || cas_trip || crc_trip || manual_trip
                      || (mf_timeout && !crc_mfas_found);
    end
  end
endmodule // e1fc_top

// >>> bench/e1fc_top_asserts.sv
// Checker: concurrent properties on the framer control top ports
module e1fc_top_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fas_word_ok,
  input wire logic fas_word_bad,
  input wire logic cas_word_ok,
  input wire logic cas_word_bad,
  input wire logic crc_mfas_found,
  input wire logic tx_positive_rail,
  input wire logic tx_negative_rail,
  input wire logic rx_data,
  input wire logic rx_data_valid,
  input wire logic resync_pulse,
  input wire logic crc4_sync,
  input wire logic [7:0] common_control,
  input wire logic [7:0] receive_control
);
  import e1fc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] fas_run_q;
  logic cas_run_q;
  logic auto_on;
  assign auto_on = !receive_control[RCV_AUTO_RESYNC_DISABLE];
  // ==========================================================================
  // Error runs; a good word or a restart starts the count again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fas_run_q <= 2'd0;
      cas_run_q <= 1'b0;
    end else begin
      if (fas_word_ok || resync_pulse) fas_run_q <= 2'd0;
      else if (fas_word_bad && fas_run_q != 2'd3) fas_run_q <= fas_run_q + 2'd1;
      if (cas_word_ok || resync_pulse) cas_run_q <= 1'b0;
      else if (cas_word_bad) cas_run_q <= 1'b1;
    end
  end
  sequence fas_third_bad;
    fas_word_bad && fas_run_q == 2'd2;
  endsequence
  sequence cas_second_bad;
    cas_word_bad && cas_run_q;
  endsequence
  // ==========================================================================
  // Properties
  rails_excl_a: assert property (!(tx_positive_rail && tx_negative_rail))
    else $error("both transmit rails high");
  fas_resync_a: assert property (fas_third_bad and auto_on |=> resync_pulse)
    else $error("no restart after three bad alignment words");
  cas_resync_a: assert property (cas_second_bad and auto_on |=> resync_pulse)
    else $error("no restart after two bad multiframe words");
  auto_off_a: assert property (fas_third_bad and !auto_on and common_control == 8'h00
    |=> !resync_pulse) else $error("restart while automatic restart is off");
  pulse_short_a: assert property (resync_pulse |=> !resync_pulse)
    else $error("restart pulse longer than one cycle");
  crc_sync_a: assert property ($rose(crc4_sync) |-> $past(crc_mfas_found))
    else $error("multiframe sync without a found alignment");
  reserved_zero_a: assert property (!common_control[7] && receive_control[7:6] == 2'b00)
    else $error("reserved register bit set");
  rx_hold_a: assert property (!rx_data_valid |=> $stable(rx_data) || rx_data_valid)
    else $error("decoded bit changed without a valid strobe");
  valid_pulse_a: assert property (rx_data_valid |=> !rx_data_valid)
    else $error("valid strobe longer than one cycle");
endmodule // e1fc_top_asserts

bind e1fc_top e1fc_top_asserts u_chk (.clk(clk), .rst_n(rst_n), .fas_word_ok(fas_word_ok),
  .fas_word_bad(fas_word_bad), .cas_word_ok(cas_word_ok), .cas_word_bad(cas_word_bad),
  .crc_mfas_found(crc_mfas_found), .tx_positive_rail(tx_positive_rail),
  .tx_negative_rail(tx_negative_rail), .rx_data(rx_data), .rx_data_valid(rx_data_valid),
  .resync_pulse(resync_pulse), .crc4_sync(crc4_sync), .common_control(common_control),
  .receive_control(receive_control));

// >>> bench/e1fc_line_model.sv
// Line side model: free-running line clocks, patterned receive rails, space-run monitor
module e1fc_line_model (
  input wire logic clr,
  input wire logic tx_positive_rail,
  input wire logic tx_negative_rail,
  output logic transmit_line_clock,
  output logic rx_line_clock,
  output logic rx_positive_rail,
  output logic rx_negative_rail,
  output int zero_run_max
);
  timeunit 1ns;
  timeprecision 1ps;
  int run;
  int p;
  // Line clocks run free; the odd start offset keeps them off the system clock edges
  initial begin
    transmit_line_clock = 1'b0;
    #1.3;
    forever #40 transmit_line_clock = ~transmit_line_clock;
  end
  initial begin
    rx_line_clock = 1'b0;
    #3.1;
    forever #20 rx_line_clock = ~rx_line_clock;
  end
  // Mark, three spaces, same-polarity mark, then the mirror: HDB3 sees substitutions
  initial begin
    rx_positive_rail = 1'b0;
    rx_negative_rail = 1'b0;
    p = 0;
    run = 0;
    zero_run_max = 0;
  end
  always @(negedge rx_line_clock) begin
    rx_positive_rail <= (p == 0) || (p == 4);
    rx_negative_rail <= (p == 5) || (p == 9);
    p <= (p + 1) % 10;
  end
  // Longest run of spaces on the transmit rails, sampled on the rising transmit line clock edge
  always @(posedge transmit_line_clock or posedge clr) begin
    if (clr) begin
      run <= 0;
      zero_run_max <= 0;
    end else if (tx_positive_rail || tx_negative_rail) begin
      run <= 0;
    end else begin
      run <= run + 1;
      if (run + 1 > zero_run_max) zero_run_max <= run + 1;
    end
  end
endmodule // e1fc_line_model

// >>> bench/e1_framer_control_registers_bench.sv
// Testbench: serial register access, restart control and line coding of the framer control
module e1_framer_control_registers_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import e1fc_pkg::*;
  logic clk, rst_n, sclk, cs_n, sdi, tsi, test_pin, fal, clr, sdo, sdo_oe_n, ccs, sgs, sgd;
  logic txp, txn, lck_t, lck_r, rxp, rxn, rxd, rxv, rsp, csync;
  logic [6:0] ev;
  logic [7:0] cmn_o, rcv_o, rd;
  int err_count, compares, rs_cnt, zmax, cmn_m, rcv_m, r0, c, v, a;
  // ==========================================================================
  // Clock and design
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  e1fc_top #(.CRC_MF_WAIT(200), .CRC_MF_WAIT_NEW(100)) uut (.clk(clk), .rst_n(rst_n),
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .transmit_line_clock(lck_t), .rx_line_clock(lck_r), .rx_positive_rail(rxp),
    .rx_negative_rail(rxn), .transmit_serial_input(tsi), .signaling_data_input(sgd),
    .test_pin(test_pin), .tx_ccs_mode(ccs), .tx_sig_from_input(sgs), .frame_aligned(fal),
    .fas_word_ok(ev[0]), .fas_word_bad(ev[1]), .cas_word_ok(ev[2]), .cas_word_bad(ev[3]),
    .crc_word_ok(ev[4]), .crc_word_bad(ev[5]), .crc_mfas_found(ev[6]),
    .tx_positive_rail(txp), .tx_negative_rail(txn), .rx_data(rxd), .rx_data_valid(rxv),
    .resync_pulse(rsp), .crc4_sync(csync), .common_control(cmn_o), .receive_control(rcv_o));
  e1fc_line_model line (.clr(clr), .tx_positive_rail(txp), .tx_negative_rail(txn),
    .transmit_line_clock(lck_t), .rx_line_clock(lck_r), .rx_positive_rail(rxp),
    .rx_negative_rail(rxn), .zero_run_max(zmax));
  // Restart requests counted as they leave the block
  always @(posedge clk) begin
    if (rsp === 1'b1) rs_cnt++;
  end
  // ==========================================================================
  // Shared tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Command byte then data byte, LSB first; a 17th pulse shows the data pin released
  task xfer(input logic [7:0] cmd, input logic [7:0] wd);
    logic [16:0] w;
    w = {1'b0, wd, cmd};
    cs_n = 1'b0;
    repeat (6) @(negedge clk);
    for (int k = 0; k < 17; k++) begin
      sdi = w[k];
      sclk = 1'b1;
      repeat (6) @(negedge clk);
      if (k > 7 && k < 16) rd[k-8] = sdo;
      chk(sdo_oe_n, !(cmd[0] && k > 7 && k < 16));
      sclk = 1'b0;
      repeat (6) @(negedge clk);
    end
    cs_n = 1'b1;
    repeat (40) @(negedge clk);
  endtask
  // Write through the port and into the model; reserved bits and unmapped places drop
  task wr(input int ad, input int vl);
    xfer({3'b000, ad[3:0], 1'b0}, vl[7:0]);
    if (ad == 1) rcv_m = vl & RCV_MASK;
    if (ad == 2) cmn_m = vl & CMN_MASK;
  endtask
  task rdr(input int ad);
    xfer({3'b000, ad[3:0], 1'b1}, 8'h00);
  endtask
  task pulse(input int b, input int n);
    repeat (n) begin
      ev[b] = 1'b1;
      @(negedge clk);
      ev[b] = 1'b0;
      repeat (3) @(negedge clk);
    end
  endtask
  // Count ones among n decoded bits; a stalled receiver ends the run
  task ones(input int n, output int cnt);
    int g;
    cnt = 0;
    for (g = 0; g < 6000 && n > 0; g++) begin
      @(negedge clk);
      if (rxv === 1'b1) begin
        n--;
        cnt += (rxd === 1'b1);
      end
    end
    if (n > 0) begin
      err_count++;
      final_report;
    end
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    {rst_n, sclk, sdi, tsi, test_pin, fal, clr, ev, ccs, sgs, sgd} = '0;
    cs_n = 1'b1;
    {err_count, compares, rs_cnt, cmn_m, rcv_m} = '0;
    void'($urandom(14057));
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    for (int i = 1; i < 3; i++) begin
      rdr(i);
      chk(rd, 8'h00);
    end
    for (int i = 0; i < 6; i++) begin
      v = $urandom % 256;
      a = (i % 3 == 2) ? 3 + $urandom % 13 : 1 + i % 3;
      v = (v & 8) ? v & 8'hbf : v;
      wr(a, v);
      rdr(a);
      chk(rd, a == 1 ? rcv_m : a == 2 ? cmn_m : 0);
      chk(cmn_o, cmn_m);
      chk(rcv_o, rcv_m);
    end
    $display("register access test done");
    wr(2, 0);
    wr(1, 0);
    r0 = rs_cnt;
    pulse(1, 2);
    pulse(0, 1);
    pulse(1, 2);
    chk(rs_cnt - r0, 0);
    pulse(1, 1);
    chk(rs_cnt - r0, 1);
    pulse(3, 1);
    pulse(2, 1);
    pulse(3, 2);
    chk(rs_cnt - r0, 2);
    wr(1, 2);
    pulse(1, 3);
    pulse(3, 2);
    chk(rs_cnt - r0, 2);
    $display("word error restart test done");
    wr(2, 2);
    for (int i = 0; i < 2000; i++) pulse((i % 1000) < 914 + i / 1000 ? 5 : 4, 1);
    chk(rs_cnt - r0, 3);
    $display("checksum error restart test done");
    wr(2, 4);
    test_pin = 1'b1;
    fal = 1'b1;
    repeat (90) @(negedge clk);
    chk(rs_cnt - r0, 3);
    repeat (60) @(negedge clk);
    chk(rs_cnt - r0, 4);
    chk(csync, 1'b0);
    fal = 1'b0;
    repeat (3) @(negedge clk);
    fal = 1'b1;
    repeat (2) @(negedge clk);
    pulse(6, 2);
    repeat (150) @(negedge clk);
    chk(csync, 1'b1);
    chk(rs_cnt - r0, 4);
    {test_pin, fal} = 2'b00;
    $display("multiframe hunt test done");
    for (int m = 0; m < 2; m++) begin
      wr(2, m * 8'h20);
      repeat (400) @(negedge clk);
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      repeat (3200) @(negedge clk);
      chk(m ? zmax <= 3 : zmax >= 4, 1);
    end
    // Signaling input held high: only common channel mode keeps timeslot 16 quiet
    {ccs, sgs, sgd} = 3'b111;
    for (int m = 0; m < 3; m++) begin
      wr(2, m == 0 ? 8'h00 : m == 1 ? 8'h10 : 8'h41);
      ones(20, c);
      ones(m < 2 ? 100 : 300, c);
      if (m < 2) chk(c, 40 - 20 * m);
      else chk(c, 0);
    end
    $display("line coding test done");
    final_report;
  end
endmodule // e1_framer_control_registers_bench
